//--- seea_ctrl.sv
// Serial configuration EEPROM controller with register port and autoload.
`timescale 1ns/1ps
`include "seea_regs.svh"
`default_nettype none

module seea_ctrl
	import seea_pkg::*;
#(
	parameter logic [15:0] SUBSYS_MAKER_RST = 16'hA5A5, // Arbitrary value.
	parameter logic [15:0] SUBSYS_ID_RST = 16'h5A5A // Arbitrary value.
)
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [2:0] sec_grant_i
);

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------

	// Bit reversal for least significant bit first streams.
	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// Kind of each step; reads need a repeated start to turn the bus round.
	function automatic seea_tok_e tok_of(input logic [2:0] s, input logic wr);
		seea_tok_e t;
		t = TK_STOP;
		if (wr)
		begin
			if (s == 3'h0)
				t = TK_START;
			else if (s <= 3'h4)
				t = TK_TX;
		end
		else
		begin
			unique case (s)
				3'h0, 3'h3: t = TK_START;
				3'h1, 3'h2, 3'h4: t = TK_TX;
				3'h5: t = TK_RX_ACK;
				3'h6: t = TK_RX_NACK;
				3'h7: t = TK_STOP;
			endcase
		end
		return t;
	endfunction

	// True when the register port address matches an offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [3:0] pin_raw; // Raw pin levels: data line first, then the three grant lines.
	logic [3:0] sy1_r; // First synchroniser stage, read only by the second.
	logic [3:0] sy2_r; // Second stage.
	logic [3:0] sy3_r; // Third stage.
	logic [3:0] agr_r; // Level accepted once stages two and three agree.
	seea_strap_s strap_r; // Options latched during reset.
	logic start_r; // Cycle requested and not yet delivered.
	logic cmd_r; // Direction of the next software cycle.
	logic err_r; // Missing acknowledge seen.
	logic succ_r; // Autoload finished without error.
	logic [1:0] rate_r; // Clock rate select.
	logic [7:0] addr_r; // EEPROM word location.
	logic [15:0] data_r; // Word to write or word read.
	logic [15:0] maker_r; // Subsystem maker identifier.
	logic [15:0] subid_r; // Subsystem identifier.
	logic [`SEEA_INT_W-1:0] ist_r; // Sticky interrupt status.
	logic [`SEEA_INT_W-1:0] imsk_r; // Interrupt mask.
	logic al_arm_r; // First cycle after reset release pending.
	logic al_act_r; // Autoload in progress.
	logic al_idx_r; // Which identifier autoload fetches.
	seea_job_s job_r; // Cycle in flight.
	logic job_nack_r; // Cycle in flight saw a missing acknowledge.
	seea_state_e st_r; // Serial engine state.
	logic [2:0] step_r; // Step within the transaction.
	logic [1:0] ph_r; // Quarter of the serial bit.
	logic [3:0] bit_r; // Bit within a byte plus acknowledge slot.
	logic [7:0] sh_r; // Shift register.
	logic [7:0] lo_r; // First byte received.
	logic [7:0] qcnt_r; // Quarter period counter.
	logic scl_r; // Serial clock level.
	logic sda_low_r; // Pulling the data line low.
	logic [9:0] div_sel; // Selected divide ratio.
	logic [7:0] qlast; // Terminal count of a quarter period.
	logic qtick; // One quarter period elapsed.
	logic launch; // Engine takes a new cycle.
	logic done; // Stop condition finished.
	logic nack; // Acknowledge slot sampled high.
	seea_tok_e tok; // Kind of the current step.
	logic [7:0] tx_byte; // Byte sent in the current step.
	logic [15:0] rx_word; // Word assembled from received bytes.
	logic wr_ctrl; // Software write to the control word.
	seea_ctrl_s ctrl_rd; // Control word as read back.
	logic [31:0] rd_nxt; // Read data for the next cycle.

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------

	// Three stages per pin; an edge counts once the last two stages agree,
	// which also rejects a single-cycle glitch at the cost of one clock of delay.
	// The pins are gathered first so that no stage indexes outside the grant bus.
	assign pin_raw = {sec_grant_i, sda_i};

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_sync
			always_ff @(posedge core_clk_i)
			begin
				sy1_r[g] <= pin_raw[g];
				sy2_r[g] <= sy1_r[g];
				sy3_r[g] <= sy2_r[g];
				if (sy2_r[g] == sy3_r[g])
					agr_r[g] <= sy3_r[g];
			end
		end
	endgenerate

	// Straps follow the grant pins while reset is low and hold after release.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			strap_r <= seea_strap_s'(agr_r[3:1]);
	end

	// ---------------------------------------------------------------
	// Shared decode
	// ---------------------------------------------------------------

	// Autoload runs by its strap speed, software cycles by the rate field.
	always_comb
	begin
		if (al_act_r)
			div_sel = strap_r.normal_speed ? `SEEA_DIV_SLOW : `SEEA_DIV_FAST;
		else if (rate_r == `SEEA_RATE_DIV128)
			div_sel = `SEEA_DIV_FAST;
		else
			div_sel = `SEEA_DIV_SLOW; // Reserved codes fall back to the slow rate.
		qlast = 8'((div_sel >> 2) - 10'h001);
	end

	assign qtick = ce_i && (st_r != ST_IDLE) && (qcnt_r == qlast);
	assign launch = ce_i && (st_r == ST_IDLE) && !al_arm_r && (al_act_r || start_r);
	assign done = qtick && (st_r == ST_STOP) && (ph_r == 2'h3);
	assign nack = qtick && (st_r == ST_BIT) && (tok == TK_TX) && (bit_r == 4'h8)
		&& (ph_r == 2'h2) && agr_r[0];
	assign tok = tok_of(step_r, job_r.wr);
	assign rx_word = strap_r.lsb_first ? {rev8(sh_r), rev8(lo_r)} : {sh_r, lo_r};
	assign wr_ctrl = ce_i && reg_wr_i && hit(reg_addr_i, `SEEA_OFF_CTRL);

	// Device codes go out most significant bit first; word bytes follow the strap.
	always_comb
	begin
		tx_byte = 8'h00;
		if (step_r == 3'h1)
			tx_byte = `SEEA_DEV_WR;
		else if (step_r == 3'h4 && !job_r.wr)
			tx_byte = `SEEA_DEV_RD;
		else if (step_r == 3'h2)
			tx_byte = strap_r.lsb_first ? rev8(job_r.addr) : job_r.addr;
		else if (step_r == 3'h3)
			tx_byte = strap_r.lsb_first ? rev8(job_r.wdata[7:0]) : job_r.wdata[7:0];
		else if (step_r == 3'h4)
			tx_byte = strap_r.lsb_first ? rev8(job_r.wdata[15:8]) : job_r.wdata[15:8];
	end

	// ---------------------------------------------------------------
	// Software-visible control
	// ---------------------------------------------------------------

	// Start is set by software outside autoload and cleared when the stop goes out.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			start_r <= 1'b0;
		else if (ce_i)
		begin
			if (done && !al_act_r)
				start_r <= 1'b0;
			else if (wr_ctrl && reg_wdata_i[0] && !al_act_r && !al_arm_r)
				start_r <= 1'b1;
		end
	end

	// Command, rate and address are plain software fields.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			cmd_r <= 1'b0;
			rate_r <= `SEEA_RATE_RST;
			addr_r <= 8'h00;
		end
		else if (wr_ctrl)
		begin
			cmd_r <= reg_wdata_i[1];
			rate_r <= reg_wdata_i[7:6];
			addr_r <= reg_wdata_i[15:8];
		end
	end

	// A finished read overrides a software write landing in the same cycle.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			data_r <= 16'h0000;
		else if (ce_i)
		begin
			if (done && !al_act_r && !job_r.wr && !job_nack_r)
				data_r <= rx_word;
			else if (wr_ctrl)
				data_r <= reg_wdata_i[31:16];
		end
	end

	// Error flag: cleared as a new software cycle starts, set on a missing acknowledge.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			err_r <= 1'b0;
		else if (ce_i)
		begin
			if (nack)
				err_r <= 1'b1;
			else if (launch && !al_act_r)
				err_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Autoload sequencing
	// ---------------------------------------------------------------

	// Two words are fetched; any missing acknowledge abandons the load.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			al_arm_r <= 1'b1;
			al_act_r <= 1'b0;
			al_idx_r <= 1'b0;
			succ_r <= 1'b0;
			maker_r <= SUBSYS_MAKER_RST;
			subid_r <= SUBSYS_ID_RST;
		end
		else if (ce_i)
		begin
			if (al_arm_r)
			begin
				al_arm_r <= 1'b0;
				al_act_r <= strap_r.al_enable;
			end
			else if (done && al_act_r)
			begin
				if (job_nack_r)
					al_act_r <= 1'b0;
				else if (!al_idx_r)
				begin
					maker_r <= rx_word;
					al_idx_r <= 1'b1;
				end
				else
				begin
					subid_r <= rx_word;
					al_act_r <= 1'b0;
					succ_r <= 1'b1;
				end
			end
		end
	end

	// The cycle is captured at launch so later register writes cannot disturb it, save the rate field, which the divider reads live.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			job_r <= '0;
			job_nack_r <= 1'b0;
		end
		else if (launch)
		begin
			job_nack_r <= 1'b0;
			if (al_act_r)
				job_r <= {1'b0, al_idx_r ? `SEEA_AL_ADDR_ID : `SEEA_AL_ADDR_MAKER, 16'h0000};
			else
				job_r <= {cmd_r, addr_r, data_r};
		end
		else if (nack)
			job_nack_r <= 1'b1;
	end

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------

	// Quarter-period divider; stopped and cleared while idle.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			qcnt_r <= 8'h00;
		else if (ce_i)
		begin
			if (st_r == ST_IDLE || qtick)
				qcnt_r <= 8'h00;
			else
				qcnt_r <= qcnt_r + 8'h01;
		end
	end

	// Each bit spends one quarter per phase: set data, raise clock, sample, drop clock.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			st_r <= ST_IDLE;
			step_r <= 3'h0;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			lo_r <= 8'h00;
			scl_r <= 1'b1;
			sda_low_r <= 1'b0;
		end
		else if (ce_i)
		begin
			unique case (st_r)
				ST_IDLE:
				begin
					if (launch)
					begin
						st_r <= ST_TOKEN;
						step_r <= 3'h0;
					end
				end
				ST_TOKEN:
				begin
					// Decode the step without waiting for a quarter tick.
					ph_r <= 2'h0;
					bit_r <= 4'h0;
					// The stop must not wipe the last byte read, which is still in the shifter.
					if (tok != TK_STOP)
						sh_r <= tx_byte;
					unique case (tok)
						TK_START: st_r <= ST_START;
						TK_TX, TK_RX_ACK, TK_RX_NACK: st_r <= ST_BIT;
						TK_STOP: st_r <= ST_STOP;
					endcase
				end
				ST_START:
				begin
					if (qtick)
					begin
						ph_r <= ph_r + 2'h1;
						unique case (ph_r)
							2'h0: sda_low_r <= 1'b0;
							2'h1: scl_r <= 1'b1;
							2'h2: sda_low_r <= 1'b1; // Data falls while clock is high.
							2'h3:
							begin
								scl_r <= 1'b0;
								step_r <= step_r + 3'h1;
								st_r <= ST_TOKEN;
							end
						endcase
					end
				end
				ST_BIT:
				begin
					if (qtick)
					begin
						ph_r <= ph_r + 2'h1;
						unique case (ph_r)
							2'h0:
							begin
								if (bit_r == 4'h8)
									sda_low_r <= (tok == TK_RX_ACK);
								else if (tok == TK_TX)
									sda_low_r <= !sh_r[7];
								else
									sda_low_r <= 1'b0;
							end
							2'h1: scl_r <= 1'b1;
							2'h2:
							begin
								if (bit_r != 4'h8 && tok != TK_TX)
									sh_r <= {sh_r[6:0], agr_r[0]};
								else if (bit_r != 4'h8)
									sh_r <= {sh_r[6:0], 1'b0};
							end
							2'h3:
							begin
								scl_r <= 1'b0;
								bit_r <= bit_r + 4'h1;
								if (bit_r == 4'h8)
								begin
									st_r <= ST_TOKEN;
									if (tok == TK_RX_ACK)
										lo_r <= sh_r;
									// A missing acknowledge skips straight to the stop.
									if (job_nack_r)
										step_r <= job_r.wr ? 3'h5 : 3'h7;
									else
										step_r <= step_r + 3'h1;
								end
							end
						endcase
					end
				end
				ST_STOP:
				begin
					if (qtick)
					begin
						ph_r <= ph_r + 2'h1;
						unique case (ph_r)
							2'h0: sda_low_r <= 1'b1;
							2'h1: scl_r <= 1'b1;
							2'h2: sda_low_r <= 1'b0; // Data rises while clock is high.
							2'h3: st_r <= ST_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	// Open-drain data pin: the pad only ever pulls low.
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_low_r;
	assign scl_o = scl_r;

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------

	// Sticky status, write one to clear; a new event wins over its clear.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			ist_r <= '0;
			imsk_r <= '0;
		end
		else if (ce_i)
		begin
			for (int i = 0; i < `SEEA_INT_W; i++)
			begin
				if ((i == `SEEA_INT_DONE && done && !al_act_r)
					|| (i == `SEEA_INT_NACK && nack)
					|| (i == `SEEA_INT_AL && done && al_act_r && (job_nack_r || al_idx_r)))
					ist_r[i] <= 1'b1;
				else if (reg_wr_i && hit(reg_addr_i, `SEEA_OFF_INT_ST) && reg_wdata_i[i])
					ist_r[i] <= 1'b0;
			end
			if (reg_wr_i && hit(reg_addr_i, `SEEA_OFF_INT_MSK))
				imsk_r <= reg_wdata_i[`SEEA_INT_W-1:0];
		end
	end

	assign irq_o = |(ist_r & imsk_r);

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------

	// Control word as seen by software; reserved bits read zero.
	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd.data = data_r;
		ctrl_rd.addr = addr_r;
		ctrl_rd.rate = rate_r;
		ctrl_rd.succ = succ_r;
		ctrl_rd.err = err_r;
		ctrl_rd.cmd = cmd_r;
		ctrl_rd.start = start_r;
	end

	// Unmapped addresses read zero.
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		if (hit(reg_addr_i, `SEEA_OFF_CTRL))
			rd_nxt = ctrl_rd;
		else if (hit(reg_addr_i, `SEEA_OFF_TEST))
		begin
			rd_nxt[`SEEA_TEST_LSB_BIT] = strap_r.lsb_first;
			rd_nxt[`SEEA_TEST_SPEED_BIT] = strap_r.normal_speed;
			rd_nxt[`SEEA_TEST_ALEN_BIT] = strap_r.al_enable;
			rd_nxt[`SEEA_TEST_SUCC_BIT] = succ_r;
			rd_nxt[`SEEA_TEST_ALDIS_BIT] = !strap_r.al_enable;
		end
		else if (hit(reg_addr_i, `SEEA_OFF_INT_ST))
			rd_nxt[`SEEA_INT_W-1:0] = ist_r;
		else if (hit(reg_addr_i, `SEEA_OFF_INT_MSK))
			rd_nxt[`SEEA_INT_W-1:0] = imsk_r;
		else if (hit(reg_addr_i, `SEEA_OFF_SUBSYS))
			rd_nxt = {subid_r, maker_r};
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (ce_i)
			reg_rdata_o <= reg_rd_i ? rd_nxt : 32'h0000_0000;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_start_hold;
		start_r && !done |=> start_r;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start dropped early");

	property p_start_clr;
		done && !al_act_r |=> !start_r;
	endproperty
	a_start_clr: assert property (p_start_clr) else $error("start not cleared");

	property p_dir;
		launch && !al_act_r |=> job_r.wr == $past(cmd_r);
	endproperty
	a_dir: assert property (p_dir) else $error("cycle direction wrong");

	property p_err;
		nack |=> err_r ##0 ist_r[`SEEA_INT_NACK];
	endproperty
	a_err: assert property (p_err) else $error("missing acknowledge not flagged");

	property p_succ;
		succ_r |-> strap_r.al_enable && !al_act_r;
	endproperty
	a_succ: assert property (p_succ) else $error("success without autoload");

	property p_div;
		qtick |-> (qcnt_r == 8'h1F && div_sel == `SEEA_DIV_FAST)
			|| (qcnt_r == 8'h3F && div_sel == `SEEA_DIV_SLOW);
	endproperty
	a_div: assert property (p_div) else $error("clock divider off");

	property p_rdata;
		done && !al_act_r && !job_r.wr && !job_nack_r |=> data_r == $past(rx_word);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read word not stored");

	property p_strap;
		$past(resetn_i) |-> $stable(strap_r);
	endproperty
	a_strap: assert property (p_strap) else $error("strap changed after reset");

	property p_rsv;
		reg_rd_i && ce_i && hit(reg_addr_i, `SEEA_OFF_TEST) |=> reg_rdata_o[23:0] == 24'h000000
			&& reg_rdata_o[31:30] == 2'h0 && !reg_rdata_o[25];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

	property p_idle_bus;
		st_r == ST_IDLE |-> scl_o && !sda_oe_o;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("bus not released when idle");

endmodule
`default_nettype wire

//--- seea_eeprom_model.sv
// Behavioural two-wire EEPROM that answers the access block on its serial pins.
`timescale 1ns/1ps
`default_nettype none

module seea_eeprom_model
(
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic nack_i,
	output logic sda_low_o
);
	// ---------------------------------------------------------------
	// Storage and framing state
	// ---------------------------------------------------------------
	// Bytes are kept by raw wire address byte and byte number, so a reversed
	// bit order shows up as a different location.
	logic [7:0] mem [0:511];
	logic [7:0] sh;
	logic [7:0] tx;
	logic [7:0] last_addr;
	logic [8:0] ptr;
	logic rd;
	logic ackd;
	int bitc;
	int nbyte;

	initial
	begin
		sda_low_o = 1'b0;
		bitc = 0;
		nbyte = 0;
		rd = 1'b0;
		ptr = 9'h000;
	end

	// A data edge while the clock is high is a start or a stop; either one
	// restarts byte framing and releases the line.
	always @(sda_i)
	begin
		if (scl_i === 1'b1)
		begin
			bitc = 0;
			nbyte = 0;
			rd = 1'b0;
			sda_low_o = 1'b0;
		end
	end

	// Bits are taken on the rising clock; the ninth is the acknowledge slot.
	always @(posedge scl_i)
	begin
		if (bitc < 8)
		begin
			sh = {sh[6:0], sda_i};
			bitc = bitc + 1;
		end
		else
		begin
			ackd = !sda_i;
			bitc = 9;
		end
	end

	// The line only moves while the clock is low.
	always @(negedge scl_i)
	begin
		if (bitc == 8 && !rd)
		begin
			if (nbyte == 0)
				rd = sh[0];
			else if (nbyte == 1)
			begin
				ptr = {sh, 1'b0};
				last_addr = sh;
			end
			else
			begin
				mem[ptr] = sh;
				ptr = ptr + 9'h001;
			end
			nbyte = nbyte + 1;
			sda_low_o = !nack_i;
		end
		else if (bitc == 9 && rd && ackd)
		begin
			tx = mem[ptr];
			ptr = ptr + 9'h001;
			bitc = 0;
			sda_low_o = !tx[7];
		end
		else if (bitc == 9)
		begin
			bitc = 0;
			sda_low_o = 1'b0;
		end
		else if (rd && bitc > 0 && bitc < 8)
			sda_low_o = !tx[7 - bitc];
		else
			sda_low_o = 1'b0;
	end
endmodule
`default_nettype wire

//--- seea_pkg.sv
// Types shared by the EEPROM access block.
`default_nettype none
package seea_pkg;

	// Serial engine states.
	typedef enum logic [2:0] {ST_IDLE, ST_TOKEN, ST_START, ST_BIT, ST_STOP} seea_state_e;

	// Kinds of step in a two-wire transaction.
	typedef enum logic [2:0] {TK_START, TK_TX, TK_RX_ACK, TK_RX_NACK, TK_STOP} seea_tok_e;

	// Layout of the control word at its shared offset.
	typedef struct packed {
		logic [15:0] data;
		logic [7:0] addr;
		logic [1:0] rate;
		logic [1:0] rsv;
		logic succ;
		logic err;
		logic cmd;
		logic start;
	} seea_ctrl_s;

	// Options caught from the grant pins during reset.
	typedef struct packed {
		logic lsb_first;
		logic normal_speed;
		logic al_enable;
	} seea_strap_s;

	// One EEPROM cycle as handed to the serial engine.
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
	} seea_job_s;

endpackage
`default_nettype wire

//--- seea_regs.svh
// Register offsets, field positions, reset values and counts of the EEPROM access block.
//
// Contract
// - Start bit launches cycle, device clears when delivered.
// - Command bit: 0 read, 1 write; resets 0.
// - Missing acknowledge sets read-only error bit.
// - Autoload success bits read 1 only after success.
// - Rate field: 01 /256, 10 /128; resets 01.
// - Address field locates each software cycle.
// - Data field sends writes, receives read word.
// - Bit 29 strap: 1 LSB first, 0 MSB first.
// - Bit 28 strap: 0 fast autoload, 1 normal.
// - Bit 27 strap: 0 bypass autoload, 1 perform.
// - Subsystem identifiers fixed, autoload may overwrite them.
// - Reserved bits read zero and reset zero.
`ifndef SEEA_REGS_SVH
`define SEEA_REGS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define SEEA_OFF_CTRL 8'hC8
`define SEEA_OFF_TEST 8'hCC
`define SEEA_OFF_INT_ST 8'hD0
`define SEEA_OFF_INT_MSK 8'hD4
`define SEEA_OFF_SUBSYS 8'hF0

// ---------------------------------------------------------------
// Field positions of the strap register
// ---------------------------------------------------------------
`define SEEA_TEST_LSB_BIT 29
`define SEEA_TEST_SPEED_BIT 28
`define SEEA_TEST_ALEN_BIT 27
`define SEEA_TEST_SUCC_BIT 26
`define SEEA_TEST_ALDIS_BIT 24

// Interrupt status bit positions.
`define SEEA_INT_DONE 0
`define SEEA_INT_NACK 1
`define SEEA_INT_AL 2
`define SEEA_INT_W 3

// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define SEEA_RATE_RST 2'h1
`define SEEA_RATE_DIV256 2'h1
`define SEEA_RATE_DIV128 2'h2
`define SEEA_DIV_SLOW 10'h100
`define SEEA_DIV_FAST 10'h080
`define SEEA_DEV_WR 8'hA0
`define SEEA_DEV_RD 8'hA1
`define SEEA_AL_ADDR_MAKER 8'h00
`define SEEA_AL_ADDR_ID 8'h01

`endif

//--- tb_top.sv
// Self-checking bench for the EEPROM access block and its serial partner.
`timescale 1ns/1ps
`include "seea_regs.svh"
`default_nettype none

module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic nack = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [2:0] grant = 3'h5;
	logic [31:0] rdata;
	logic [31:0] v;
	logic irq, scl, sda_oe, sda_dr, mdl_low, sda_w;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;

	always #20 clk = ~clk;
	// The data line has a pull-up; either party pulls it low.
	assign sda_w = !mdl_low && (sda_oe ? sda_dr : 1'b1);

	seea_ctrl #(.SUBSYS_MAKER_RST(16'h1357), .SUBSYS_ID_RST(16'h2468)) uut (
		.core_clk_i(clk), .resetn_i(resetn), .ce_i(1'b1), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.irq_o(irq), .scl_o(scl), .sda_i(sda_w), .sda_o(sda_dr), .sda_oe_o(sda_oe),
		.sec_grant_i(grant));
	seea_eeprom_model mdl (.scl_i(scl), .sda_i(sda_w), .nack_i(nack), .sda_low_o(mdl_low));

	// ---------------------------------------------------------------
	// Shared bus and compare tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Bounded poll of one register bit.
	task automatic poll(input logic [7:0] a, input int b, input logic e);
		int i;
		for (i = 0; i < 15000; i++)
		begin
			rreg(a, v);
			if (v[b] === e)
				break;
		end
		chk("poll bit", {31'h0, e}, {31'h0, v[b]});
	endtask

	// Serial clock period in core cycles between two rising edges.
	task automatic per(input int e);
		time t;
		@(posedge scl);
		t = $time;
		@(posedge scl);
		chk("scl period", e, 32'(($time - t) / 40));
	endtask

	// Straps are held steady for the whole reset.
	task automatic rst(input logic [2:0] g);
		@(posedge clk);
		resetn <= 1'b0;
		grant <= g;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	// Word 1 sits at raw address 80 because the address goes out LSB first.
	task automatic t_autoload;
		mdl.mem[0] = 8'h66;
		mdl.mem[1] = 8'h24;
		mdl.mem[256] = 8'h99;
		mdl.mem[257] = 8'h18;
		// The first reset lasts five edges; the straps stand from time zero.
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		per(128);
		poll(`SEEA_OFF_INT_ST, `SEEA_INT_AL, 1'b1);
		rreg(`SEEA_OFF_TEST, v);
		chk("test reg", 32'h2C000000, v);
		rreg(`SEEA_OFF_CTRL, v);
		chk("ctrl low half", 32'h48, v & 32'hFFFF);
		rreg(`SEEA_OFF_SUBSYS, v);
		chk("subsystem ids", 32'h18992466, v);
	endtask

	task automatic t_write;
		wreg(`SEEA_OFF_CTRL, 32'h12340583);
		rreg(`SEEA_OFF_CTRL, v);
		chk("start held", 1, v[0]);
		per(128);
		poll(`SEEA_OFF_CTRL, 0, 1'b0);
		chk("wire address", 8'hA0, mdl.last_addr);
		chk("wire low byte", 8'h2C, mdl.mem[320]);
		chk("wire high byte", 8'h48, mdl.mem[321]);
		rreg(`SEEA_OFF_CTRL, v);
		chk("ctrl after write", 32'h1234058A, v);
	endtask

	task automatic t_read;
		wreg(`SEEA_OFF_CTRL, 32'h00000541);
		per(256);
		poll(`SEEA_OFF_CTRL, 0, 1'b0);
		rreg(`SEEA_OFF_CTRL, v);
		chk("ctrl after read", 32'h12340548, v);
	endtask

	task automatic t_irq;
		chk("irq masked", 0, irq);
		wreg(`SEEA_OFF_INT_MSK, 32'h1);
		@(negedge clk);
		chk("irq unmasked", 1, irq);
		wreg(`SEEA_OFF_INT_ST, 32'h7);
		@(negedge clk);
		chk("irq cleared", 0, irq);
		rreg(`SEEA_OFF_INT_ST, v);
		chk("status cleared", 0, v);
		wreg(`SEEA_OFF_INT_MSK, 32'h0);
	endtask

	task automatic t_nack;
		nack = 1'b1;
		wreg(`SEEA_OFF_CTRL, 32'h77770531);
		poll(`SEEA_OFF_CTRL, 0, 1'b0);
		rreg(`SEEA_OFF_CTRL, v);
		chk("ctrl after nack", 32'h7777050C, v);
		rreg(`SEEA_OFF_INT_ST, v);
		chk("nack status", 1, v[`SEEA_INT_NACK]);
		nack = 1'b0;
	endtask

	task automatic t_misc;
		rreg(8'h80, v);
		chk("unmapped", 0, v);
		wreg(`SEEA_OFF_TEST, 32'hFFFFFFFF);
		wreg(`SEEA_OFF_SUBSYS, 32'h0);
		rreg(`SEEA_OFF_TEST, v);
		chk("test reg ro", 32'h2C000000, v);
		rreg(`SEEA_OFF_SUBSYS, v);
		chk("ids ro", 32'h18992466, v);
	endtask

	task automatic t_bypass;
		rst(3'h2);
		repeat (4) @(posedge clk);
		rreg(`SEEA_OFF_TEST, v);
		chk("test reg bypass", 32'h11000000, v);
		rreg(`SEEA_OFF_CTRL, v);
		chk("ctrl reset", 32'h00000040, v);
		rreg(`SEEA_OFF_SUBSYS, v);
		chk("default ids", 32'h24681357, v);
		wreg(`SEEA_OFF_CTRL, 32'h12340583);
		poll(`SEEA_OFF_CTRL, 0, 1'b0);
		chk("msb address", 8'h05, mdl.last_addr);
		chk("msb low byte", 8'h34, mdl.mem[10]);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		t_autoload();
		t_write();
		t_read();
		t_irq();
		t_nack();
		t_misc();
		t_bypass();
		report_and_stop();
	end

	// The run needs some 40000 cycles; the ceiling leaves ample slack.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
